/* core/fbrd_ctrl.sv */
// Flash block read, read-ahead, page status, unprotect and discard control
`timescale 1ns/10ps
`include "fbrd_params.svh"
module fbrd_ctrl
  import fbrd_pkg::*;
#(
  parameter int SECTORS = 32,
  parameter int PAGES = 64,
  parameter logic [23:0] THRESHOLD = 24'h002710
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read_request,
  input wire logic [1:0] read_source,
  input wire logic read_ahead_select,
  input wire logic page_info_select,
  input wire logic pipe_select,
  input wire fbrd_addr_t addr,
  input wire logic clear_guard_request,
  input wire logic drop_buffer_request,
  input wire logic buffer_hold_guard,
  input wire logic buffer_modified_in,
  input wire logic [31:0] array_data,
  input wire logic [31:0] array_fix,
  input wire logic [1:0] array_err,
  input wire logic [31:0] page_buf_data,
  input wire logic [31:0] block_buf_data,
  input wire logic [31:0] dev_status_word,
  output logic busy,
  output logic [31:0] read_data,
  output logic [1:0] status,
  output logic buffer_modified,
  output logic buffer_copy,
  output logic [10:0] buffer_page
);
  localparam int AW = 11;
  // Block timer counts array cycles; the copy adds one write-back cycle per block
  localparam logic [3:0] ARRAY_LAT = 4'(`FBRD_ARRAY_CYCLES);
  localparam logic [3:0] COPY_BLOCKS = 4'(`FBRD_BLOCKS_PER_PAGE);
  fbrd_state_t state_reg;
  fbrd_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] blk_reg;
  logic [3:0] blk_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] src_reg;
  logic [1:0] src_next;
  logic info_reg;
  logic info_next;
  logic mod_reg;
  logic mod_next;
  logic [AW-1:0] bufpage_reg;
  logic [AW-1:0] bufpage_next;
  logic [AW-1:0] cur_index_reg;
  logic [AW-1:0] cur_index_next;
  fbrd_addr_t predict_reg;
  fbrd_addr_t predict_next;
  logic ahead_valid_reg;
  logic ahead_valid_next;
  fbrd_addr_t predicted;
  fbrd_page_status_t meta_status;
  logic clr_pulse;
  logic [3:0] fetch_wait;

  // ********************************
  // Helpers
  // ********************************
  // Flat page index from sector and page fields
  function automatic logic [AW-1:0] page_index(input fbrd_addr_t a);
    page_index = {a.sector, a.page};
  endfunction : page_index

  // Fold ECC outcome into read data: corrected on single, raw on double
  function automatic logic [31:0] ecc_data(input logic [31:0] raw, input logic [31:0] fix,
                                           input logic [1:0] err);
    ecc_data = (err == `FBRD_ST_SBE) ? fix : raw;
  endfunction : ecc_data

  // ********************************
  // Submodules
  // ********************************
  // Prediction is taken from the live address so it is ready at the take edge
  fbrd_next_addr #(.SECTORS(SECTORS), .PAGES(PAGES)) u_next (
    .cur(addr),
    .nxt(predicted)
  );

  // Status is read from the latched index so a moving address cannot corrupt it
  fbrd_page_meta #(.PAGES_TOTAL(1 << AW), .AW(AW), .THRESHOLD(THRESHOLD)) u_meta (
    .clk(clk),
    .rst_n(rst_n),
    .rd_index(cur_index_reg),
    .rd_status(meta_status),
    .clr_guard(clr_pulse),
    .clr_index(page_index(addr))
  );

  // Array access time, plus one stage in pipe mode
  assign fetch_wait = pipe_select ? ARRAY_LAT + 4'h1 : ARRAY_LAT;

  // ********************************
  // Operation sequencer
  // ********************************
  // Fixed priority: read first, then unprotect, then discard
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    blk_next = blk_reg;
    data_next = data_reg;
    status_next = status_reg;
    src_next = src_reg;
    info_next = info_reg;
    mod_next = mod_reg;
    bufpage_next = bufpage_reg;
    cur_index_next = cur_index_reg;
    predict_next = predict_reg;
    ahead_valid_next = ahead_valid_reg;
    clr_pulse = 1'b0;
    case (state_reg)
      FBRD_IDLE: begin
        mod_next = mod_reg | buffer_modified_in;
        if (read_request) begin
          status_next = `FBRD_ST_OK;
          src_next = read_source;
          info_next = page_info_select;
          cur_index_next = page_index(addr);
          state_next = FBRD_FETCH;
          if (page_info_select) begin
            cnt_next = fetch_wait;
          end else if (read_ahead_select && ahead_valid_reg && addr == predict_reg) begin
            cnt_next = 4'h1; // Hit: data already prefetched
          end else if (read_ahead_select && ahead_valid_reg) begin
            // Miss: finish pending prefetch, then fetch anew, capped at nine
            // Pipe stage costs one more cycle but busy never exceeds nine
            cnt_next = 4'(`FBRD_MISS_MAX_BUSY) - (pipe_select ? 4'h1 : 4'h2);
          end else begin
            cnt_next = (read_source == `FBRD_SRC_ARRAY) ? fetch_wait : 4'h1;
          end
          predict_next = predicted;
          ahead_valid_next = read_ahead_select;
        end else if (clear_guard_request) begin
          status_next = `FBRD_ST_OK;
          clr_pulse = 1'b1;
          ahead_valid_next = 1'b0;
          // Page already buffered: only the guard is cleared, no copy needed
          if (page_index(addr) == bufpage_reg) begin
            state_next = FBRD_FINISH;
          end else if (buffer_hold_guard && mod_reg) begin
            status_next = `FBRD_ST_LOSS;
            state_next = FBRD_FINISH;
          end else if (buffer_hold_guard) begin
            // Unmodified but held buffer is not replaced, status stays clean
            state_next = FBRD_FINISH;
          end else begin
            bufpage_next = page_index(addr);
            blk_next = 4'h0;
            cnt_next = ARRAY_LAT + 4'h1;
            state_next = FBRD_COPY;
          end
        end else if (drop_buffer_request) begin
          status_next = `FBRD_ST_OK;
          state_next = FBRD_DROP;
        end
      end
      FBRD_FETCH: begin
        // Count down the access time; the last count moves to delivery
        if (cnt_reg <= 4'h1) begin
          state_next = FBRD_DELIVER;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      FBRD_DELIVER: begin
        // Data and status land together as busy falls
        if (info_reg) begin
          data_next = meta_status;
        end else begin
          case (src_reg)
            `FBRD_SRC_ARRAY: begin
              data_next = ecc_data(array_data, array_fix, array_err);
              status_next = (array_err == `FBRD_ST_LOSS) ? `FBRD_ST_DBE : array_err;
            end
            `FBRD_SRC_PAGEBUF: data_next = page_buf_data;
            `FBRD_SRC_BLOCKBUF: data_next = block_buf_data;
            default: data_next = dev_status_word;
          endcase
        end
        state_next = FBRD_IDLE;
      end
      FBRD_COPY: begin
        // One block: array read then buffer write; double error outranks single
        if (cnt_reg <= 4'h1) begin
          if (array_err[1]) begin
            status_next = `FBRD_ST_DBE;
          end else if (array_err == `FBRD_ST_SBE && status_reg != `FBRD_ST_DBE) begin
            status_next = `FBRD_ST_SBE;
          end
          if (blk_reg == COPY_BLOCKS - 4'h1) begin
            mod_next = 1'b0;
            state_next = FBRD_FINISH;
          end else begin
            blk_next = blk_reg + 4'h1;
            cnt_next = ARRAY_LAT + 4'h1;
          end
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      FBRD_DROP: begin
        // Only the modified mark is dropped; buffer contents stay as they are
        mod_next = 1'b0;
        state_next = FBRD_FINISH;
      end
      FBRD_FINISH: begin
        // Extra busy cycle so no request lands on the last buffer update
        state_next = FBRD_IDLE;
      end
      default: begin
        state_next = FBRD_IDLE;
      end
    endcase
  end

  // ********************************
  // State registers
  // ********************************
  // Registers only; all decisions are in the process above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FBRD_IDLE;
      cnt_reg <= 4'h0;
      blk_reg <= 4'h0;
      data_reg <= 32'h00000000;
      status_reg <= `FBRD_ST_OK;
      src_reg <= `FBRD_SRC_ARRAY;
      info_reg <= 1'b0;
      mod_reg <= 1'b0;
      bufpage_reg <= '0;
      cur_index_reg <= '0;
      predict_reg <= '0;
      ahead_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      blk_reg <= blk_next;
      data_reg <= data_next;
      status_reg <= status_next;
      src_reg <= src_next;
      info_reg <= info_next;
      mod_reg <= mod_next;
      bufpage_reg <= bufpage_next;
      cur_index_reg <= cur_index_next;
      predict_reg <= predict_next;
      ahead_valid_reg <= ahead_valid_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Busy is combinational so a request is refused in the very cycle work starts
  assign busy = (state_reg != FBRD_IDLE);
  assign read_data = data_reg;
  assign status = status_reg;
  assign buffer_modified = mod_reg;
  // Copy flag lets the far side see the buffer being refilled
  assign buffer_copy = (state_reg == FBRD_COPY);
  assign buffer_page = bufpage_reg;
endmodule : fbrd_ctrl

/* core/fbrd_next_addr.sv */
// Look-ahead address predictor for read-ahead mode
`timescale 1ns/10ps
`include "fbrd_params.svh"
module fbrd_next_addr
  import fbrd_pkg::*;
#(
  parameter int SECTORS = 32,
  parameter int PAGES = 64
) (
  input wire fbrd_addr_t cur,
  output fbrd_addr_t nxt
);
  // ********************************
  // Prediction
  // ********************************
  // Combinational so the prediction is ready when the current read is taken
  always_comb begin
    nxt = cur;
    if (cur.aux) begin
      // Auxiliary block of next linear page
      nxt.page = cur.page + 6'h01;
      if (cur.page == 6'(PAGES - 1)) begin
        nxt.sector = (cur.sector == 5'(SECTORS - 1)) ? 5'h00 : cur.sector + 5'h01;
      end
    end else if (cur.spare) begin
      nxt.block = 4'h0;
      nxt.sector = (cur.sector == 5'(SECTORS - 1)) ? 5'h00 : cur.sector + 5'h01;
    end else if (cur.block == 4'(`FBRD_BLOCKS_PER_PAGE - 1)) begin
      nxt.block = 4'h0;
      nxt.page = cur.page + 6'h01;
      if (cur.page == 6'(PAGES - 1)) begin
        nxt.sector = (cur.sector == 5'(SECTORS - 1)) ? 5'h00 : cur.sector + 5'h01;
      end
    end else begin
      nxt.block = cur.block + 4'h1;
    end
  end
endmodule : fbrd_next_addr

/* core/fbrd_page_meta.sv */
// Per-page metadata store: write counts and protection flags
`timescale 1ns/10ps
`include "fbrd_params.svh"
module fbrd_page_meta
  import fbrd_pkg::*;
#(
  parameter int PAGES_TOTAL = 2048,
  parameter int AW = 11,
  parameter logic [23:0] THRESHOLD = 24'h002710
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] rd_index,
  output fbrd_page_status_t rd_status,
  input wire logic clr_guard,
  input wire logic [AW-1:0] clr_index
);
  logic [23:0] count_mem [PAGES_TOTAL];
  logic [2:0] flag_mem [PAGES_TOTAL];
  logic [PAGES_TOTAL-1:0] guard_reg;
  logic [PAGES_TOTAL-1:0] guard_next;
  fbrd_page_status_t rd_next;
  fbrd_page_status_t rd_reg;
  // ********************************
  // Status word assembly
  // ********************************
  // Counts and flags have no write port; they keep the zeros set by the initial block
  always_comb begin
    guard_next = guard_reg;
    if (clr_guard) begin
      guard_next[clr_index] = 1'b0;
    end
    rd_next.write_count = count_mem[rd_index];
    rd_next.reserved = 4'h0;
    rd_next.over_threshold = count_mem[rd_index] > THRESHOLD;
    rd_next.read_protected = flag_mem[rd_index][2];
    rd_next.write_protected = flag_mem[rd_index][1];
    rd_next.overwrite_guard = guard_reg[rd_index];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg <= '0;
      rd_reg <= '0;
    end else begin
      guard_reg <= guard_next;
      rd_reg <= rd_next;
    end
  end
  assign rd_status = rd_reg;
  initial begin
    for (int i = 0; i < PAGES_TOTAL; i++) begin
      count_mem[i] = 24'h000000;
      flag_mem[i] = 3'h0;
    end
  end
endmodule : fbrd_page_meta

/* core/fbrd_params.svh */
// Constants for the flash block read and page operation controller
`ifndef FBRD_PARAMS_SVH
`define FBRD_PARAMS_SVH
`define FBRD_ST_OK 2'h0
`define FBRD_ST_SBE 2'h1
`define FBRD_ST_DBE 2'h2
`define FBRD_ST_LOSS 2'h3
`define FBRD_PS_COUNT_LSB 8
`define FBRD_PS_OVER_BIT 3
`define FBRD_PS_RDPROT_BIT 2
`define FBRD_PS_WRPROT_BIT 1
`define FBRD_PS_GUARD_BIT 0
`define FBRD_ARRAY_CYCLES 5
`define FBRD_MISS_MAX_BUSY 9
`define FBRD_BLOCKS_PER_PAGE 9
`define FBRD_SRC_ARRAY 2'h0
`define FBRD_SRC_PAGEBUF 2'h1
`define FBRD_SRC_BLOCKBUF 2'h2
`define FBRD_SRC_STATUS 2'h3
`endif

/* core/fbrd_pkg.sv */
// Types shared by the flash block read and page operation controller
package fbrd_pkg;
  typedef struct packed {
    logic [23:0] write_count;
    logic [3:0] reserved;
    logic over_threshold;
    logic read_protected;
    logic write_protected;
    logic overwrite_guard;
  } fbrd_page_status_t;
  typedef struct packed {
    logic [4:0] sector;
    logic [5:0] page;
    logic [3:0] block;
    logic spare;
    logic aux;
  } fbrd_addr_t;
  typedef enum logic [5:0] {
    FBRD_IDLE = 6'h01,
    FBRD_FETCH = 6'h02,
    FBRD_DELIVER = 6'h04,
    FBRD_COPY = 6'h08,
    FBRD_DROP = 6'h10,
    FBRD_FINISH = 6'h20
  } fbrd_state_t;
endpackage : fbrd_pkg

/* test/fbrd_ctrl_properties.sv */
// Port-level timing checker for the flash block read controller
`timescale 1ns/10ps
module fbrd_ctrl_properties
  import fbrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read_request,
  input wire logic [1:0] read_source,
  input wire logic read_ahead_select,
  input wire logic pipe_select,
  input wire logic clear_guard_request,
  input wire logic drop_buffer_request,
  input wire logic busy,
  input wire logic [31:0] read_data,
  input wire logic [1:0] status,
  input wire logic buffer_modified,
  input wire logic buffer_copy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Requests that the controller accepts; anything seen while busy is dropped
  wire logic take = !busy && (read_request || clear_guard_request || drop_buffer_request);
  wire logic plain_rd = !busy && read_request && read_source == 2'h0 && !read_ahead_select;
  a_take_busy: assert property (take |=> busy)
    else $error("busy did not rise after an accepted request");
  a_status_clear: assert property (take |=> status == 2'h0 ||
    (status == 2'h3 && $past(clear_guard_request && !read_request)))
    else $error("status not cleared when an operation started");
  a_status_hold: assert property (!busy && !take |=> $stable(status) && $stable(read_data))
    else $error("outputs changed while idle");
  a_array_lat: assert property (plain_rd && !pipe_select |=> busy [*6] ##1 !busy)
    else $error("array read latency wrong without pipe stage");
  a_pipe_lat: assert property (plain_rd && pipe_select |=> busy [*7] ##1 !busy)
    else $error("array read latency wrong with pipe stage");
  a_miss_bound: assert property (!busy && read_request && read_ahead_select |=> ##[1:9] !busy)
    else $error("read-ahead access took too long");
  a_drop_done: assert property (!busy && drop_buffer_request && !read_request &&
    !clear_guard_request |=> busy ##1 busy ##1 (!busy && !buffer_modified))
    else $error("discard did not finish with buffer unmodified");
  a_copy_busy: assert property (buffer_copy |-> busy)
    else $error("page copy ran while not busy");
  a_copy_length: assert property ($rose(buffer_copy) |-> ##53 buffer_copy
    ##1 !buffer_copy ##1 !busy)
    else $error("page copy did not take nine blocks of six cycles");
endmodule : fbrd_ctrl_properties

/* test/fbrd_src_model.sv */
// Behavioural model of the array and buffer data sources
`timescale 1ns/10ps
module fbrd_src_model
  import fbrd_pkg::*;
(
  input wire logic [31:0] word,
  input wire logic [1:0] err,
  output logic [31:0] array_data,
  output logic [31:0] array_fix,
  output logic [1:0] array_err,
  output logic [31:0] page_buf_data,
  output logic [31:0] block_buf_data,
  output logic [31:0] dev_status_word
);
  // Raw word carries the flipped bits so an uncorrected delivery is visible
  assign array_fix = word;
  assign array_data = (err == 2'h0) ? word : word ^ ((err == 2'h1) ? 32'h0000_0001 : 32'h0000_0003);
  assign array_err = err;
  // Distinct patterns per source so a wrong select cannot match
  assign page_buf_data = word ^ 32'h1111_1111;
  assign block_buf_data = word ^ 32'h2222_2222;
  assign dev_status_word = word ^ 32'h3333_3333;
endmodule : fbrd_src_model

/* test/tb_fbrd_ctrl.sv */
// Self-checking testbench of the flash block read controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_fbrd_ctrl
  import fbrd_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, read_request = 1'b0, read_ahead_select = 1'b0;
  logic page_info_select = 1'b0, pipe_select = 1'b0, clear_guard_request = 1'b0;
  logic drop_buffer_request = 1'b0, buffer_hold_guard = 1'b0, buffer_modified_in = 1'b0;
  logic inj = 1'b0, prev_busy = 1'b0;
  logic [1:0] read_source = 2'h0, err = 2'h0;
  logic [31:0] word = 32'h0000_0000, rs = 32'h0000_0F65;
  fbrd_addr_t addr = '0;
  wire logic [31:0] array_data, array_fix, page_buf_data, block_buf_data, dev_status_word;
  wire logic [31:0] read_data;
  wire logic [1:0] array_err, status;
  wire logic busy, buffer_modified, buffer_copy;
  wire logic [10:0] buffer_page;
  int fail_count = 0, n_checks = 0;
  typedef struct {logic m; logic [31:0] d; logic [1:0] s;} fbrd_exp_t;
  fbrd_exp_t q[$];
  always #2 clk = ~clk;
  fbrd_ctrl uut (.clk(clk), .rst_n(rst_n), .read_request(read_request),
    .read_source(read_source), .read_ahead_select(read_ahead_select),
    .page_info_select(page_info_select), .pipe_select(pipe_select), .addr(addr),
    .clear_guard_request(clear_guard_request), .drop_buffer_request(drop_buffer_request),
    .buffer_hold_guard(buffer_hold_guard), .buffer_modified_in(buffer_modified_in),
    .array_data(array_data), .array_fix(array_fix), .array_err(array_err),
    .page_buf_data(page_buf_data), .block_buf_data(block_buf_data),
    .dev_status_word(dev_status_word), .busy(busy), .read_data(read_data), .status(status),
    .buffer_modified(buffer_modified), .buffer_copy(buffer_copy), .buffer_page(buffer_page));
  fbrd_src_model u_src (.word(word), .err(err), .array_data(array_data),
    .array_fix(array_fix), .array_err(array_err), .page_buf_data(page_buf_data),
    .block_buf_data(block_buf_data), .dev_status_word(dev_status_word));
  // ****************************************
  // Stimulus helpers
  // ****************************************
  function automatic logic [31:0] next_rand();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : next_rand
  // Note the expectation, issue one request while idle, count busy cycles
  task automatic go(input logic [2:0] k, input fbrd_addr_t a, input logic m,
                    input logic [31:0] d, input logic [1:0] s, output int n);
    q.push_back('{m, d, s});
    @(negedge clk);
    {read_request, clear_guard_request, drop_buffer_request} = k;
    addr = a;
    @(negedge clk);
    {read_request, clear_guard_request, drop_buffer_request} = 3'h0;
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      drop_buffer_request = inj && n == 2; // Stray request while busy must be ignored
    end
    if (n >= 200) begin
      fail_count++;
    end
  endtask : go
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // Results are compared when busy falls, oldest expectation first
  always @(negedge clk) begin
    fbrd_exp_t e;
    if (prev_busy === 1'b1 && busy === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      `CHK("status", e.s, status)
      if (e.m) `CHK("read_data", e.d, read_data)
    end
    prev_busy = busy;
  end
  // Watchdog: whole sequence needs far fewer cycles than this
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    fbrd_addr_t ra[10];
    ra = '{{5'h03, 6'h02, 4'h3, 2'h0}, {5'h03, 6'h02, 4'h4, 2'h0},
           {5'h03, 6'h02, 4'h8, 2'h0}, {5'h03, 6'h03, 4'h0, 2'h0},
           {5'h03, 6'h00, 4'h0, 2'h2}, {5'h04, 6'h00, 4'h0, 2'h2},
           {5'h1F, 6'h00, 4'h0, 2'h2}, {5'h00, 6'h00, 4'h0, 2'h2},
           {5'h03, 6'h02, 4'h0, 2'h1}, {5'h03, 6'h03, 4'h0, 2'h1}};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    `CHK("busy", 1'b0, busy)
    // Array reads, both pipe settings, every error code
    for (int i = 0; i < 8; i++) begin
      pipe_select = i[2];
      err = i[1:0];
      word = next_rand();
      go(3'h4, 17'(next_rand()), 1'b1, (i[1] ? word ^ 32'h0000_0003 : word),
         (i[1:0] == 2'h3 ? 2'h2 : i[1:0]), n);
      `CHK("array_busy", 6 + i[2], n)
    end
    {err, pipe_select} = 3'h0;
    for (int s = 1; s < 4; s++) begin
      read_source = s[1:0];
      word = next_rand();
      go(3'h4, '0, 1'b1, word ^ 32'(32'h1111_1111 * s), 2'h0, n);
      `CHK("source_busy", 2, n)
    end
    read_source = 2'h0;
    page_info_select = 1'b1;
    go(3'h4, '0, 1'b1, 32'h0000_0000, 2'h0, n);
    `CHK("info_busy", 6, n)
    page_info_select = 1'b0;
    // Miss then predicted address for each look-ahead case
    read_ahead_select = 1'b1;
    for (int i = 0; i < 10; i += 2) begin
      go(3'h4, ra[i], 1'b0, 32'h0, 2'h0, n);
      `CHK("miss_busy", 1'b1, n <= 9)
      go(3'h4, ra[i + 1], 1'b0, 32'h0, 2'h0, n);
      `CHK("hit_busy", 2, n)
    end
    read_ahead_select = 1'b0;
    // Unprotect with copy, single then double error
    for (int i = 1; i < 3; i++) begin
      err = i[1:0];
      go(3'h2, {5'h02, 6'(i), 6'h00}, 1'b0, 32'h0, i[1:0], n);
      `CHK("copy_busy", 55, n)
      `CHK("buffer_page", {5'h02, 6'(i)}, buffer_page)
    end
    err = 2'h0;
    buffer_modified_in = 1'b1;
    @(negedge clk);
    buffer_modified_in = 1'b0;
    buffer_hold_guard = 1'b1;
    go(3'h2, {5'h07, 6'h09, 6'h00}, 1'b0, 32'h0, 2'h3, n);
    `CHK("buffer_page", {5'h02, 6'h02}, buffer_page)
    inj = 1'b1;
    go(3'h4, '0, 1'b0, 32'h0, 2'h0, n);
    inj = 1'b0;
    `CHK("modified", 1'b1, buffer_modified)
    go(3'h1, '0, 1'b0, 32'h0, 2'h0, n);
    `CHK("drop_busy", 2, n)
    go(3'h2, {5'h07, 6'h09, 6'h00}, 1'b0, 32'h0, 2'h0, n);
    `CHK("buffer_page", {5'h02, 6'h02}, buffer_page)
    buffer_hold_guard = 1'b0;
    // Simultaneous read and unprotect: the read wins
    read_source = 2'h1;
    word = next_rand();
    go(3'h6, {5'h09, 6'h01, 6'h00}, 1'b1, word ^ 32'h1111_1111, 2'h0, n);
    `CHK("buffer_page", {5'h02, 6'h02}, buffer_page)
    give_verdict();
  end
endmodule : tb_fbrd_ctrl
bind fbrd_ctrl fbrd_ctrl_properties u_chk (.clk(clk), .rst_n(rst_n),
  .read_request(read_request), .read_source(read_source),
  .read_ahead_select(read_ahead_select), .pipe_select(pipe_select),
  .clear_guard_request(clear_guard_request), .drop_buffer_request(drop_buffer_request),
  .busy(busy), .read_data(read_data), .status(status), .buffer_modified(buffer_modified),
  .buffer_copy(buffer_copy));
